// ===== axstrm_pkg.sv
// axstrm_pkg: shared constants for the stream channel ends
// assumes a single clock domain and an active-low asynchronous reset
package axstrm_pkg;

    // bits per byte, the unit each sub-channel field width must be a multiple of
    localparam int unsigned FIELD_BITS   = 8;
    // default number of sub-channel fields in tdata
    localparam int unsigned FIELD_COUNT  = 2;
    // default width of each field, a whole number of bytes
    localparam int unsigned FIELD_W      = 16;
    // default user sideband width
    localparam int unsigned USER_W       = 4;
    // depth of the skid buffer in the destination
    localparam int unsigned SKID_DEPTH   = 2;
    // values after reset
    localparam logic        VALID_RST    = 1'b0;
    localparam logic        READY_RST    = 1'b0;
    localparam logic [1:0]  COUNT_RST    = 2'h0;

endpackage : axstrm_pkg

// ===== axstrm_if.sv
// axstrm_if: one point-to-point stream channel
// assumes both ends share i_clk; testbench joins the two modports
`timescale 1ns/1ns
interface axstrm_if
#(
    parameter int unsigned DATA_W = 32,
    parameter int unsigned USER_W = 4
);
    logic              tvalid;
    logic              tready;
    logic [DATA_W-1:0] tdata;
    logic [DATA_W/8-1:0] tstrb;
    logic [USER_W-1:0] tuser;
    logic              tlast;

    modport master
    (
        output tvalid,
        output tdata,
        output tstrb,
        output tuser,
        output tlast,
        input  tready
    );

    modport slave
    (
        input  tvalid,
        input  tdata,
        input  tstrb,
        input  tuser,
        input  tlast,
        output tready
    );
endinterface : axstrm_if

// ===== axstrm_source.sv
// axstrm_source: master end, takes words from the user and presents beats
// assumes user request pins synchronous to I_CLK
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module axstrm_source
#(
    parameter int unsigned DATA_W = 32,
    parameter int unsigned USER_W = 4
)
(
    input  wire logic              I_CLK,
    input  wire logic              I_RST_B,
    input  wire logic              I_CE,
    input  wire logic              I_WR,
    input  wire logic [DATA_W-1:0] I_DATA,
    input  wire logic [USER_W-1:0] I_USER,
    input  wire logic              I_LAST,
    output logic                   O_BUSY,
    axstrm_if.master               m_axis
);

    logic              valid_q;
    logic [DATA_W-1:0] data_q;
    logic [USER_W-1:0] user_q;
    logic              last_q;
    logic              busy_q;

    wire fire    = valid_q & m_axis.tready;
    wire can_ld  = ~valid_q | fire;
    wire load    = I_WR & can_ld;
    wire valid_d = load | (valid_q & ~fire);

    ////////////////////////////////////////////////////////////////////////
    // hold valid
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            valid_q <= axstrm_pkg::VALID_RST;
            busy_q  <= 1'b0;
        end
        else if (I_CE)
        begin
            valid_q <= valid_d;
            busy_q  <= valid_d;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            data_q <= '0;
            user_q <= '0;
            last_q <= 1'b0;
        end
        else if (I_CE && load)
        begin
            data_q <= I_DATA;
            user_q <= I_USER;
            last_q <= I_LAST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs registered, strobe tied high
    assign m_axis.tvalid = valid_q;
    assign m_axis.tdata  = data_q;
    assign m_axis.tstrb  = '1;
    assign m_axis.tuser  = user_q;
    assign m_axis.tlast  = last_q;
    // busy tells the user a beat is still pending; a new word is taken this cycle if no beat is pending or tready is high
    assign O_BUSY        = busy_q;

endmodule : axstrm_source

// ===== axstrm_sink.sv
// axstrm_sink: slave end with a two-entry skid buffer, fields split out
// assumes the master keeps valid and payload steady while pending

`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Function
// - only tvalid is mandatory
// - transfer when valid and ready high
// - payload meaningful only on handshake
// - valid held until ready seen
// - payload stable while beat pending
// - ready before, with or after valid
// - valid never depends on ready
// - no combinational input to output path
// - ready held early or registered
// - drive ready independent of valid
// - avoid combinational paths within group
// - reverse info never through ready
// - absent ready treated as one
// - ports named role_class_signal
// - sub-channels in byte-aligned fields, no logic
module axstrm_sink
#(
    parameter int unsigned FIELD_W     = axstrm_pkg::FIELD_W,
    parameter int unsigned FIELD_COUNT = axstrm_pkg::FIELD_COUNT,
    parameter int unsigned USER_W      = axstrm_pkg::USER_W,
    // tie high to model a destination with no ready
    parameter bit          NO_READY    = 1'b0
)
(
    input  wire logic                      I_CLK,
    input  wire logic                      I_RST_B,
    input  wire logic                      I_CE,
    axstrm_if.slave                        s_axis,
    input  wire logic                      I_TAKE,
    output logic                           O_VALID,
    output logic [FIELD_COUNT*FIELD_W-1:0] O_DATA,
    output logic [USER_W-1:0]              O_USER,
    output logic                           O_LAST,
    output logic [FIELD_W-1:0]             O_FIELD [FIELD_COUNT]
);

    localparam int unsigned DATA_W = FIELD_COUNT * FIELD_W;
    localparam int unsigned ENT_W  = DATA_W + USER_W + 1;

    if (FIELD_W % axstrm_pkg::FIELD_BITS != 0)
    begin : g_bad_field
        $error("field width must be whole bytes");
    end

    logic [ENT_W-1:0] mem_q [axstrm_pkg::SKID_DEPTH];
    logic [1:0]       cnt_q;
    logic             rd_q;
    logic             wr_q;
    logic             ready_q;
    logic             ovalid_q;
    logic [ENT_W-1:0] out_q;

    ////////////////////////////////////////////////////////////////////////
    // absent ready is one
    wire ready_eff = NO_READY ? 1'b1 : ready_q;
    wire push      = s_axis.tvalid & ready_eff;
    wire out_free  = ~ovalid_q | I_TAKE;
    wire have      = cnt_q != 2'h0;
    wire pop       = have & out_free;
    wire [1:0] cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    // held high in advance
    // without ready nothing is refused, so a stall then loses words
    wire ready_d   = NO_READY ? 1'b1 : (cnt_d < 2'(axstrm_pkg::SKID_DEPTH));
    wire [ENT_W-1:0] in_ent = {s_axis.tlast, s_axis.tuser, s_axis.tdata};
    wire [ENT_W-1:0] head   = mem_q[rd_q];
    // pointers toggle, so a depth of two needs no wrap logic
    wire rd_d      = rd_q ^ pop;
    wire wr_d      = wr_q ^ push;
    // a word stays on the output until the user takes it
    wire ovalid_d  = pop | (ovalid_q & ~I_TAKE);

    ////////////////////////////////////////////////////////////////////////
    // reset empties buffer
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            cnt_q <= axstrm_pkg::COUNT_RST;
        end
        else if (I_CE)
        begin
            cnt_q <= cnt_d;
        end
    end

    // both pointers restart together, so stale entries are never read
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end
        else if (I_CE)
        begin
            rd_q <= rd_d;
            wr_q <= wr_d;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ready_q <= axstrm_pkg::READY_RST;
        end
        else if (I_CE)
        begin
            ready_q <= ready_d;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ovalid_q <= 1'b0;
        end
        else if (I_CE)
        begin
            ovalid_q <= ovalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage has no reset; an entry is only read after it was written
    always_ff @(posedge I_CLK)
    begin
        if (I_CE && push)
        begin
            mem_q[wr_q] <= in_ent;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_CE && pop)
        begin
            out_q <= head;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ready registered
    assign s_axis.tready = ready_q;
    assign O_VALID       = ovalid_q;
    assign O_DATA        = out_q[DATA_W-1:0];
    assign O_USER        = out_q[DATA_W +: USER_W];
    assign O_LAST        = out_q[ENT_W-1];

    for (genvar f = 0; f < FIELD_COUNT; f++)
    begin : g_field
        assign O_FIELD[f] = out_q[f*FIELD_W +: FIELD_W];
    end

endmodule : axstrm_sink

// ===== axstrm_chk_sva.sv
// axstrm_chk_sva: protocol checks on one stream channel
// assumes it sits beside the interface, one clock domain
`timescale 1ns/1ns
//////////////////////////////////////
module axstrm_chk_sva
(
    input  wire logic        I_CLK,
    input  wire logic        I_RST_B,
    input  wire logic        tvalid,
    input  wire logic        tready,
    input  wire logic [31:0] tdata,
    input  wire logic [3:0]  tstrb,
    input  wire logic [3:0]  tuser,
    input  wire logic        tlast
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    valid_hold_a: assert property
        (tvalid && !tready |=> tvalid) else $error("valid withdrawn");
    valid_drop_a: assert property
        ($fell(tvalid) |-> $past(tready)) else $error("valid fell early");
    data_stable_a: assert property
        (tvalid && !tready |=> $stable(tdata)) else $error("data moved");
    side_stable_a: assert property
        (tvalid && !tready |=> $stable({tuser, tlast}))
        else $error("sideband moved");
    strb_full_a: assert property
        (tvalid |-> tstrb == 4'hF) else $error("strobe not full");
    // outside reset, ready only drops the cycle after valid was high, as when a beat fills the buffer
    ready_fall_a: assert property
        ($fell(tready) |-> $past(tvalid)) else $error("ready fell idle");
    reset_quiet_a: assert property
        (disable iff (1'b0) !I_RST_B |-> !tvalid && !tready)
        else $error("active in reset");
    ready_wake_a: assert property
        (disable iff (1'b0) $rose(I_RST_B) |=> tready)
        else $error("ready late after reset");
endmodule : axstrm_chk_sva

// ===== testbench.sv
// testbench: source and sink joined through one stream channel
// assumes a 100 MHz clock and the hand-over timing of both ends
`timescale 1ns/1ns
//////////////////////////////////////
module testbench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b1;
    logic        wr = 1'b0;
    logic        take = 1'b0;
    logic        ce = 1'b1;
    logic [31:0] data = 32'h0;
    logic        busy;
    logic        o_valid;
    logic [31:0] o_data;
    logic [3:0]  o_user;
    logic        o_last;
    logic [15:0] o_field [2];
    logic [31:0] exp_q [$];
    logic [31:0] rx_q [$];
    int          n_fail = 0;
    int          comparisons = 0;

    axstrm_if #(.DATA_W(32), .USER_W(4)) bus ();
    axstrm_source #(.DATA_W(32), .USER_W(4)) axstrm_source_inst (
        .I_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_WR(wr),
        .I_DATA(data), .I_USER(data[3:0]), .I_LAST(data[4]),
        .O_BUSY(busy), .m_axis(bus.master));
    axstrm_sink axstrm_sink_inst (
        .I_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .s_axis(bus.slave),
        .I_TAKE(take), .O_VALID(o_valid), .O_DATA(o_data),
        .O_USER(o_user), .O_LAST(o_last), .O_FIELD(o_field));
    axstrm_chk_sva axstrm_chk_sva_inst (
        .I_CLK(clk), .I_RST_B(rst_b), .tvalid(bus.tvalid),
        .tready(bus.tready), .tdata(bus.tdata), .tstrb(bus.tstrb),
        .tuser(bus.tuser), .tlast(bus.tlast));
//////////////////////////////////////
    initial forever #5 clk = ~clk;

    task check(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            n_fail++;
            $display("MISMATCH %0t value differs", $time);
        end
    endtask : check

    // expected fields come from the word that was sent, not from the output
    always @(posedge clk)
        if (o_valid && take)
        begin : b_mon
            logic [31:0] w;
            w = exp_q[rx_q.size()];
            check(o_field[0], w[15:0]);
            check(o_field[1], w[31:16]);
            check({o_user, o_last}, {w[3:0], w[4]});
            rx_q.push_back(o_data);
        end

    // a refused offer just stays up until the source is free
    task put(input logic [31:0] d);
        @(posedge clk);
        wr   <= 1'b1;
        data <= d;
        exp_q.push_back(d);
        do @(negedge clk); while (busy && !bus.tready);
        @(posedge clk);
        wr <= 1'b0;
    endtask : put

    task drain;
        for (int k = 0; k < 40 && rx_q.size() < exp_q.size(); k++)
            @(posedge clk);
        check(rx_q.size(), exp_q.size());
        foreach (exp_q[i])
            check(rx_q[i], exp_q[i]);
        exp_q.delete();
        rx_q.delete();
    endtask : drain

    task t_flow;
        @(posedge clk);
        take <= 1'b1;
        for (int n = 0; n < 4; n++)
            put(32'h0F1E2D30 + n * 32'h01010111);
        drain();
    endtask : t_flow

    // receiver stalls: buffer fills, the last beat waits on the link
    task t_stall;
        @(posedge clk);
        take <= 1'b0;
        for (int n = 0; n < 4; n++)
            put(32'hC3A50017 + n * 32'h10203001);
        repeat (3) @(negedge clk);
        check(bus.tvalid, 1'b1);
        check(bus.tready, 1'b0);
        @(posedge clk);
        take <= 1'b1;
        drain();
    endtask : t_stall

    // clock enable low freezes both ends with a beat still pending
    task t_ce;
        @(posedge clk);
        take <= 1'b1;
        put(32'h3C96_A5E1);
        ce <= 1'b0;
        repeat (4) @(negedge clk);
        check(bus.tvalid, 1'b1);
        check(busy, 1'b1);
        check(o_valid, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        drain();
    endtask : t_ce

    task t_reset;
        @(posedge clk);
        take <= 1'b0;
        for (int n = 0; n < 4; n++)
            put(32'h5A5A0F00 + n);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(negedge clk);
        check(bus.tvalid, 1'b0);
        check(o_valid, 1'b0);
        check(bus.tready, 1'b0);
        check(busy, 1'b0);
        @(posedge clk);
        rst_b <= 1'b1;
        take  <= 1'b1;
        exp_q.delete();
        put(32'h7E81_9A1C);
        drain();
    endtask : t_reset

    task stop_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    initial
    begin
        #20000;
        n_fail++;
        stop_test();
    end

    initial
    begin
        // a time-zero update lets every flop with an asynchronous reset see the falling reset edge
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_flow();
        t_stall();
        t_ce();
        t_reset();
        stop_test();
    end
endmodule : testbench
